// ---- rtl/tdm_out_pkg.sv ----
// types shared by the output stream driver
package tdm_out_pkg;
  typedef enum logic [1:0] {
    RATE_2M  = 2'b00,
    RATE_4M  = 2'b01,
    RATE_8M  = 2'b10,
    RATE_16M = 2'b11
  } rate_t;

  typedef struct packed {
    logic             mode32;
    rate_t [15:0]     rate;
  } port_cfg_t;

  typedef struct packed {
    logic             tick;
    logic [11:0]      cnt;
    logic             started;
  } link_time_t;

  typedef struct packed {
    logic [15:0]      bits;
    logic [15:0]      flag;
  } port_state_t;

  typedef struct packed {
    logic             clk_s1;
    logic             clk_s2;
    logic             clk_s3;
    logic             frm_s1;
    logic             frm_s2;
    logic             frm_last;
    logic [11:0]      cnt;
    logic             started;
    logic [15:0]      frames;
    logic [1:0]       ctrl;
    logic [31:0]      rate_bp;
    logic [31:0]      rate_loc;
    logic [31:0]      prdata;
    logic             rd_ready;
  } top_state_t;
endpackage

// ---- rtl/tdm_out_port.sv ----
// one port: sixteen serial output streams and two buffer controls
`timescale 1ns/1ps
`include "tdm_out_regs.svh"
module tdm_out_port (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire tdm_out_pkg::port_cfg_t cfg,
  input  wire tdm_out_pkg::link_time_t lt,
  input  wire logic                   reset_state,
  input  wire logic                   drive_en,
  input  wire logic                   mem_we,
  input  wire logic [12:0]            mem_idx,
  input  wire logic [8:0]             mem_wdata,
  output logic [8:0]                  mem_rdata,
  output logic [15:0]                 serial_o,
  output logic [15:0]                 serial_oe,
  output logic [1:0]                  drive_ctl
);
  import tdm_out_pkg::*;

  logic [8:0]  mem [0:8191];
  port_state_t q;
  port_state_t d;
  logic        en;
  logic [15:0] act;
  logic        mem_bit0;

  // ==========================================================
  // channel memory: data byte plus drive flag per stream and channel
  always_ff @(posedge pclk)
  begin
    if (mem_we)
    begin
      mem[mem_idx] <= mem_wdata;
    end
  end
  assign mem_rdata = mem[mem_idx];

  // ==========================================================
  // bit sequencing, each stream steps at its own rate except in fast mode
  always_comb
  begin
    logic [2:0]  k;
    logic [11:0] pos;
    logic [8:0]  w;
    k = 3'd0;
    pos = 12'h000;
    w = 9'h000;
    d = q;
    for (int s = 0; s < 16; s++)
    begin
      k = cfg.mode32 ? 3'd0 : (`SLOW_SHIFT - {1'b0, cfg.rate[s]});
      pos = lt.cnt >> k;
      w = mem[{4'(s), pos[11:3]}];
      if (cfg.mode32 && s >= 8)
      begin
        d.bits[s] = 1'b1;
        d.flag[s] = 1'b0;
      end
      else if (lt.tick && ((lt.cnt & ((12'h001 << k) - 12'h001)) == 12'h000))
      begin
        d.bits[s] = w[3'd7 - pos[2:0]];
        d.flag[s] = w[`MEM_FLAG_B];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '{bits: `SER_IDLE, flag: 16'h0000};
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // pin drive; reset and enable pin act without the clock
  assign en        = presetn & drive_en & lt.started;
  assign act       = cfg.mode32 ? `MASK_FAST : 16'hffff;
  assign serial_o  = en ? (q.bits | ~act) : `SER_IDLE;
  // reset-state low: streams never float, the outside buffers do it
  assign serial_oe = !reset_state ? 16'hffff :
                     (en ? (q.flag & act) : 16'h0000);
  assign drive_ctl[0] = en & (|(q.flag & act & `MASK_EVEN));
  assign drive_ctl[1] = en & (|(q.flag & act & `MASK_ODD));

  assign mem_bit0 = mem[{4'h0, lt.cnt[11:3]}][3'd7 - lt.cnt[2:0]];

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ode_off;
    !drive_en |-> drive_ctl == 2'b00 && serial_o == `SER_IDLE;
  endproperty
  a_ode_off: assert property (p_ode_off)
    else $error("enable pin low but outputs active");

  property p_unused_rest;
    cfg.mode32 |-> serial_o[15:8] == 8'hff && serial_oe[15:8] == {8{~reset_state}};
  endproperty
  a_unused_rest: assert property (p_unused_rest)
    else $error("upper streams not at rest in fast mode");

  property p_always_driven;
    !reset_state |-> serial_oe == 16'hffff;
  endproperty
  a_always_driven: assert property (p_always_driven)
    else $error("stream released with reset-state low");

  property p_flag_oe;
    reset_state && en && !cfg.mode32 |-> serial_oe == q.flag;
  endproperty
  a_flag_oe: assert property (p_flag_oe)
    else $error("stream drive does not follow channel flag");

  property p_rate16_hold;
    lt.tick && !cfg.mode32 && cfg.rate[0] == RATE_16M && lt.cnt[0] |=> $stable(q.bits[0]);
  endproperty
  a_rate16_hold: assert property (p_rate16_hold)
    else $error("16 Mbps stream stepped on odd tick");

  property p_rate2_hold;
    lt.tick && !cfg.mode32 && cfg.rate[1] == RATE_2M && lt.cnt[3:0] != 4'h0
      |=> $stable(q.bits[1]);
  endproperty
  a_rate2_hold: assert property (p_rate2_hold)
    else $error("2 Mbps stream stepped early");

  property p_fast_bit;
    lt.tick && cfg.mode32 |=> q.bits[0] == $past(mem_bit0);
  endproperty
  a_fast_bit: assert property (p_fast_bit)
    else $error("fast stream bit not from channel memory");

  property p_ctl_fast_odd;
    en && cfg.mode32 && (q.flag[7:0] & 8'haa) == 8'h00 |-> !drive_ctl[1];
  endproperty
  a_ctl_fast_odd: assert property (p_ctl_fast_odd)
    else $error("odd control driven by unused stream");

  property p_ctl_even;
    en && !cfg.mode32 && q.flag[14] |-> drive_ctl[0];
  endproperty
  a_ctl_even: assert property (p_ctl_even)
    else $error("even control missed stream 14");

  property p_ctl_idle;
    en && q.flag == 16'h0000 |-> drive_ctl == 2'b00;
  endproperty
  a_ctl_idle: assert property (p_ctl_idle)
    else $error("buffer enabled with no channel flagged");

  c_fast: cover property (en && cfg.mode32 && drive_ctl[0]);
  c_flagged: cover property (en && reset_state && serial_oe != 16'h0000);
endmodule

// ---- rtl/tdm_out_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef TDM_OUT_REGS_SVH
`define TDM_OUT_REGS_SVH

// ==========================================================
// register map (byte addresses)
`define OFS_CTRL      18'h00000
`define OFS_RATE_BP   18'h00004
`define OFS_RATE_LOC  18'h00008
`define OFS_STATUS    18'h0000c
`define MEM_REGION_B  17
`define MEM_PORT_B    15

// ==========================================================
// fields and reset values
`define CTRL_BP32_B   0
`define CTRL_LOC32_B  1
`define CTRL_RST      2'h0
`define RATE_RST      32'h00000000
`define MEM_FLAG_B    8
`define SER_IDLE      16'hffff
`define MASK_FAST     16'h00ff
`define MASK_EVEN     16'h5555
`define MASK_ODD      16'haaaa

// ==========================================================
// timing: one tick per link clock edge, one tick is one 32.768 Mbps bit
`define FRAME_TICKS   4096
`define SLOW_SHIFT    3'd4

`endif

// ---- rtl/tdm_output_stream_driver.sv ----
// output stream driver: link timing, apb registers, two ports
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "tdm_out_regs.svh"
module tdm_output_stream_driver (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [17:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_bit_clk,
  input  wire logic        link_frame_n,
  input  wire logic        output_drive_enable,
  input  wire logic        backplane_out_reset_state,
  input  wire logic        local_out_reset_state,
  output logic [15:0]      backplane_serial_out_o,
  output logic [15:0]      backplane_serial_out_oe,
  output logic [15:0]      local_serial_out_o,
  output logic [15:0]      local_serial_out_oe,
  output logic [1:0]       backplane_channel_drive_ctl,
  output logic [1:0]       local_channel_drive_ctl
);
  import tdm_out_pkg::*;

  top_state_t q;
  top_state_t d;
  link_time_t lt;
  port_cfg_t  cfg_bp;
  port_cfg_t  cfg_loc;
  logic       acc;
  logic       hit_mem;
  logic       mapped;
  logic       we_bp;
  logic       we_loc;
  logic [8:0] rd_bp;
  logic [8:0] rd_loc;

  // ==========================================================
  // decode
  assign acc     = psel & penable;
  assign hit_mem = paddr[`MEM_REGION_B];
  assign mapped  = hit_mem || paddr == `OFS_CTRL || paddr == `OFS_RATE_BP
                   || paddr == `OFS_RATE_LOC || paddr == `OFS_STATUS;
  // one wait state so read data comes from a flop
  assign pready  = acc & q.rd_ready;
  assign pslverr = pready & ~mapped;
  assign prdata  = q.prdata;
  assign we_bp   = pready & pwrite & hit_mem & ~paddr[`MEM_PORT_B];
  assign we_loc  = pready & pwrite & hit_mem & paddr[`MEM_PORT_B];

  // ==========================================================
  // link timing from the sampled bit clock and frame pulse
  assign lt.tick    = q.clk_s2 ^ q.clk_s3;
  assign lt.cnt     = q.cnt;
  assign lt.started = q.started;

  assign cfg_bp.mode32  = q.ctrl[`CTRL_BP32_B];
  assign cfg_bp.rate    = q.rate_bp;
  assign cfg_loc.mode32 = q.ctrl[`CTRL_LOC32_B];
  assign cfg_loc.rate   = q.rate_loc;

  // ==========================================================
  // next state
  always_comb
  begin
    d = q;
    d.clk_s1 = link_bit_clk;
    d.clk_s2 = q.clk_s1;
    d.clk_s3 = q.clk_s2;
    d.frm_s1 = link_frame_n;
    d.frm_s2 = q.frm_s1;
    // frame starts on the first tick that sees the pulse low
    if (lt.tick)
    begin
      d.frm_last = q.frm_s2;
      if (!q.frm_s2 && q.frm_last)
      begin
        d.cnt     = 12'h000;
        d.started = 1'b1;
        d.frames  = q.frames + 16'h0001;
      end
      else
      begin
        d.cnt = q.cnt + 12'h001;  // wraps after one frame of ticks
      end
    end
    // first access cycle latches read data, second completes
    if (acc && !q.rd_ready)
    begin
      d.rd_ready = 1'b1;
      if (hit_mem)
      begin
        d.prdata = {23'h000000, paddr[`MEM_PORT_B] ? rd_loc : rd_bp};
      end
      else if (paddr == `OFS_CTRL)
      begin
        d.prdata = {30'h00000000, q.ctrl};
      end
      else if (paddr == `OFS_RATE_BP)
      begin
        d.prdata = q.rate_bp;
      end
      else if (paddr == `OFS_RATE_LOC)
      begin
        d.prdata = q.rate_loc;
      end
      else if (paddr == `OFS_STATUS)
      begin
        d.prdata = {q.frames, 15'h0000, q.started};
      end
      else
      begin
        d.prdata = 32'h00000000;
      end
    end
    if (pready)
    begin
      d.rd_ready = 1'b0;
      if (pwrite && paddr == `OFS_CTRL)
      begin
        d.ctrl = pwdata[1:0];
      end
      else if (pwrite && paddr == `OFS_RATE_BP)
      begin
        d.rate_bp = pwdata;
      end
      else if (pwrite && paddr == `OFS_RATE_LOC)
      begin
        d.rate_loc = pwdata;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '{clk_s1: 1'b0, clk_s2: 1'b0, clk_s3: 1'b0, frm_s1: 1'b1, frm_s2: 1'b1,
             frm_last: 1'b1, cnt: 12'h000, started: 1'b0, frames: 16'h0000,
             ctrl: `CTRL_RST, rate_bp: `RATE_RST, rate_loc: `RATE_RST,
             prdata: 32'h00000000, rd_ready: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // ports
  tdm_out_port u_bp (
    .pclk        (pclk),
    .presetn     (presetn),
    .cfg         (cfg_bp),
    .lt          (lt),
    .reset_state (backplane_out_reset_state),
    .drive_en    (output_drive_enable),
    .mem_we      (we_bp),
    .mem_idx     (paddr[14:2]),
    .mem_wdata   (pwdata[8:0]),
    .mem_rdata   (rd_bp),
    .serial_o    (backplane_serial_out_o),
    .serial_oe   (backplane_serial_out_oe),
    .drive_ctl   (backplane_channel_drive_ctl)
  );

  tdm_out_port u_loc (
    .pclk        (pclk),
    .presetn     (presetn),
    .cfg         (cfg_loc),
    .lt          (lt),
    .reset_state (local_out_reset_state),
    .drive_en    (output_drive_enable),
    .mem_we      (we_loc),
    .mem_idx     (paddr[14:2]),
    .mem_wdata   (pwdata[8:0]),
    .mem_rdata   (rd_loc),
    .serial_o    (local_serial_out_o),
    .serial_oe   (local_serial_out_oe),
    .drive_ctl   (local_channel_drive_ctl)
  );

  // ==========================================================
  // checks
  property p_frame_start;
    @(posedge pclk) disable iff (!presetn)
    lt.tick && !q.frm_s2 && q.frm_last |=> q.cnt == 12'h000 && q.started;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame start did not clear bit counter");

  property p_init_quiet;
    @(posedge pclk) disable iff (!presetn)
    !q.started |-> backplane_channel_drive_ctl == 2'b00 && local_channel_drive_ctl == 2'b00;
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("buffer control active before first frame");

  // ==========================================================
  // register bus checks: one wait state, then exactly one ready cycle
  property p_ready_wait;
    @(posedge pclk) disable iff (!presetn)
    acc && !q.rd_ready |=> q.rd_ready;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("access phase did not reach its ready cycle");

  property p_ready_once;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("ready held for more than one cycle");

  // a refused access must not leak stale read data
  property p_err_data;
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> prdata == 32'h00000000;
  endproperty
  a_err_data: assert property (p_err_data)
    else $error("refused access returned data");

  // mode bits land at the completing edge only
  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
    pready && pwrite && paddr == `OFS_CTRL |=> q.ctrl == $past(pwdata[1:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("mode write did not land");

  property p_rate_write;
    @(posedge pclk) disable iff (!presetn)
    pready && pwrite && paddr == `OFS_RATE_LOC |=> q.rate_loc == $past(pwdata);
  endproperty
  a_rate_write: assert property (p_rate_write)
    else $error("local rate write did not land");

  // ==========================================================
  // pin level checks across both ports
  property p_bp_fast_rest;
    @(posedge pclk) disable iff (!presetn)
    q.ctrl[`CTRL_BP32_B] |-> backplane_serial_out_o[15:8] == 8'hff;
  endproperty
  a_bp_fast_rest: assert property (p_bp_fast_rest)
    else $error("backplane upper stream carried data in fast mode");

  property p_loc_fast_rest;
    @(posedge pclk) disable iff (!presetn)
    q.ctrl[`CTRL_LOC32_B] |-> local_serial_out_o[15:8] == 8'hff;
  endproperty
  a_loc_fast_rest: assert property (p_loc_fast_rest)
    else $error("local upper stream carried data in fast mode");

  // the enable pin is not synchronised, so the controls drop in the same cycle
  property p_ode_ctl;
    @(posedge pclk) disable iff (!presetn)
    !output_drive_enable |-> backplane_channel_drive_ctl == 2'b00
      && local_channel_drive_ctl == 2'b00;
  endproperty
  a_ode_ctl: assert property (p_ode_ctl)
    else $error("buffer control active with enable pin low");

  c_bp_fast: cover property (@(posedge pclk) q.ctrl[`CTRL_BP32_B] && q.started);
  c_ode_low: cover property (@(posedge pclk) q.started && !output_drive_enable);
  c_wr: cover property (@(posedge pclk) we_loc);
endmodule

// ---- verif/tdm_link_partner.sv ----
// far-side model: free-running link bit clock and frame pulse
`timescale 1ns/1ps
module tdm_link_partner (
  output logic link_bit_clk,
  output logic link_frame_n
);
  int ticks;

  // ==========================================
  // link timing
  // every edge is one tick; the pulse changes mid-tick so it is
  // never sampled on its own transition
  initial
  begin
    link_bit_clk = 1'b0;
    link_frame_n = 1'b1;
    ticks = 2048;
    forever
    begin
      #16 link_frame_n = (ticks % 4096) != 4095;
      #16 link_bit_clk = ~link_bit_clk;
      ticks++;
    end
  end
endmodule

// ---- verif/tdm_output_stream_driver_tb.sv ----
// bench for the output stream driver: registers, frames, straps
`timescale 1ns/1ps
`include "tdm_out_regs.svh"
module tdm_output_stream_driver_tb;
  import tdm_out_pkg::*;
  typedef struct packed {logic [17:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic        pclk, presetn, psel, penable, pwrite, odrv, bp_rs, loc_rs, pready, pslverr, e;
  logic        lclk, lfrm_n;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] bp_o, bp_oe, loc_o, loc_oe;
  logic [1:0]  bp_ctl, loc_ctl;
  int          num_errors = 0, checks = 0, cyc = 0, t, i, p, s;

  function automatic logic [17:0] ma(input logic pt, input logic [3:0] st, input logic [8:0] c);
    return {2'b10, pt, st, c, 2'b00};
  endfunction

  row_t rows [12] = '{
    '{`OFS_CTRL, 32'h3, 32'h3, 1'b0}, '{`OFS_CTRL, 32'h0, 32'h0, 1'b0},
    '{`OFS_RATE_BP, '1, '1, 1'b0}, '{`OFS_RATE_BP, 32'hc, 32'hc, 1'b0},
    '{`OFS_RATE_LOC, 32'h5a5a5a5a, 32'h5a5a5a5a, 1'b0}, '{`OFS_RATE_LOC, 0, 0, 1'b0},
    '{`OFS_STATUS, '1, 0, 1'b0}, '{18'h00010, '1, 0, 1'b1},
    '{ma(0, 0, 0), 32'h1a5, 32'h1a5, 1'b0}, '{ma(0, 1, 0), 32'h3c, 32'h3c, 1'b0},
    '{ma(0, 1, 1), 32'h1c3, 32'h1c3, 1'b0}, '{ma(1, 2, 0), 32'h1ff, 32'h1ff, 1'b0}};

  tdm_output_stream_driver tdm_output_stream_driver_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_bit_clk(lclk),
    .link_frame_n(lfrm_n), .output_drive_enable(odrv), .backplane_out_reset_state(bp_rs),
    .local_out_reset_state(loc_rs), .backplane_serial_out_o(bp_o),
    .backplane_serial_out_oe(bp_oe), .local_serial_out_o(loc_o),
    .local_serial_out_oe(loc_oe), .backplane_channel_drive_ctl(bp_ctl),
    .local_channel_drive_ctl(loc_ctl));
  tdm_link_partner tdm_link_partner_i (.link_bit_clk(lclk), .link_frame_n(lfrm_n));

  // ==========================================
  // clock and cycle count
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer; pready and read data taken at the rising edge that ends it
  task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 16)
    begin
      num_errors++;
      complete_run();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic at(input int n);
    while (cyc < n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // returns the cycle of the link edge that starts a frame
  task automatic wait_frame(output int tf);
    logic lv;
    int   k;
    for (k = 0; k < 40000 && lfrm_n !== 1'b0; k++) @(posedge pclk);
    lv = lclk;
    for (k = k; k < 40008 && lclk === lv; k++) @(posedge pclk);
    if (k >= 40000)
    begin
      num_errors++;
      complete_run();
    end
    tf = cyc;
  endtask

  task automatic rest_chk();
    chk({bp_o, loc_o}, '1);
    chk({bp_oe, loc_oe}, 32'hffff0000);
    chk({bp_ctl, loc_ctl}, 0);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, bp_rs, paddr, pwdata} = '0;
    odrv = 1'b1;
    loc_rs = 1'b1;
    repeat (10) @(posedge pclk);
    rest_chk();
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      apb(18'(4 * i), 1'b0, 0);
      chk(rd, 0);
    end
    rest_chk();
    // unwritten flags would leave the shared controls unknown
    for (p = 0; p < 32; p++) apb(ma(p[4], p[3:0], 0), 1'b1, 0);
    for (p = 1; p < 8; p++) apb(ma(0, 1, p[8:0]), 1'b1, 0);
    foreach (rows[i])
    begin
      apb(rows[i].a, 1'b1, rows[i].d);
      chk(e, rows[i].e);
      apb(rows[i].a, 1'b0, 0);
      chk({rd, e}, {rows[i].x, rows[i].e});
    end
    // stream 0 at 2 Mbps and stream 1 at 16 Mbps in the same frame
    wait_frame(t);
    for (i = 0; i < 64; i++)
    begin
      at(t + 9 + 8 * i);
      chk(bp_o[0], (8'ha5 >> (7 - i / 8)) & 8'h01);
      chk(bp_o[1], i < 16 ? (16'h3cc3 >> (15 - i)) & 16'h0001 : 0);
      chk(bp_ctl, {i / 8 == 1, 1'b1});
      chk({loc_oe, loc_o[2], loc_ctl}, {16'h0004, 3'b101});
    end
    @(posedge pclk);
    odrv <= 1'b0;
    @(negedge pclk);
    rest_chk();
    @(posedge pclk);
    odrv <= 1'b1;
    apb(ma(0, 9, 0), 1'b1, 32'h100);
    apb(`OFS_CTRL, 1'b1, 32'h3);
    bp_rs <= 1'b1;
    loc_rs <= 1'b0;
    wait_frame(t);
    for (i = 0; i < 7; i++)
    begin
      at(t + 8 + 4 * i);
      chk(bp_o[0], (8'ha5 >> (7 - i)) & 8'h01);
      chk({bp_o[15:8], loc_o[15:8]}, 16'hffff);
      chk({bp_oe, loc_oe}, 32'h0001ffff);
      chk({bp_ctl, loc_ctl}, 4'b0101);
    end
    apb(`OFS_STATUS, 1'b0, 0);
    chk(rd[0], 1'b1);
    complete_run();
  end
endmodule
